/* dio_port_resource_router_tb.sv */
// Self-checking bench for the port router
`timescale 1ns/1ns
`include "dprr_map.svh"
module dio_port_resource_router_tb import dprr_pkg::*;;
    localparam logic [15:0] P0  = `DPRR_IDX_PORT_0_3 * 4;
    localparam logic [15:0] RPB = `DPRR_IDX_ROUTE_PB * 4;
    localparam logic [15:0] R23 = `DPRR_IDX_ROUTE_2_3 * 4;
    localparam logic [15:0] BAD = 16'h0008;
    localparam logic [1:0]  OK  = `DPRR_RESP_OKAY;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] pin_in, pin_out, pin_oe, lvl, a;
    logic [15:0] ext_level = 16'h0;
    logic        pushbutton_in = 1'b0, pulse_out_a = 1'b0;
    logic        pulse_out_b = 1'b0, eeprom_do = 1'b0, eeprom_oe = 1'b0;
    dprr_res_s   resources;
    logic [33:0] q[$];
    logic [33:0] note;
    logic [2:0]  sel[11];
    logic [31:0] rnd, v, vold;
    logic [5:0]  eb, ob;
    integer      seed = 32'h14bc;
    int          mismatches = 0, checks = 0, cycles = 0;

    always #50 aclk = ~aclk;

    dprr_top i_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe,
        .pushbutton_in, .pulse_out_a, .pulse_out_b, .eeprom_do, .eeprom_oe,
        .resources
    );
    dprr_board i_board (.pin_out, .pin_oe, .ext_level, .pin_in);

    ////////////////////////////////////////
    function automatic logic [3:0] res_of(input logic [31:0] p);
        logic [3:0] e;
        logic       b;
        e = 4'h0;
        for (int k = 0; k < 11; k++)
        begin
            b = (k == 10) ? p[16] : p[k + 2];
            case (sel[k])
                3'h2: e[3] |= b;
                3'h3: e[2] |= b;
                3'h4: e[1] |= b;
                3'h5: e[0] |= b;
                default: ;
            endcase
        end
        return e;
    endfunction : res_of

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic complete_run();
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    // Random late ready
    task automatic wr(input logic [15:0] ad, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge aclk);
        q.push_back({r, 32'h0});
        rnd = $random(seed);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= rnd[0];
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready)
                s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] ad, input logic [33:0] e);
        @(posedge aclk);
        q.push_back(e);
        rnd = $random(seed);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= rnd[0];
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready)
                s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    endtask : rd

    always @(posedge aclk)
    begin
        if (s_axi_bvalid && s_axi_bready)
        begin
            note = q.pop_front();
            chk("bresp", {30'h0, note[33:32]}, {30'h0, s_axi_bresp});
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            note = q.pop_front();
            chk("rresp", {30'h0, note[33:32]}, {30'h0, s_axi_rresp});
            chk("rdata", note[31:0], s_axi_rdata);
        end
    end

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            complete_run();
        end
    end

    ////////////////////////////////////////
    initial
    begin
        rnd = $random(seed);
        ext_level <= rnd[15:0];
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("pin_oe", 32'h0, {16'h0, pin_oe});
        chk("pin_out", 32'hffff, {16'h0, pin_out});
        rd(P0, {OK, 28'h0, ext_level[3:0]});
        for (int i = 0; i < 4; i++)
        begin
            v = $random(seed);
            a = P0 + {8'h0, i[1:0], 6'h0};
            lvl[4*i +: 4] = v[3:0];
            wr(a, 32'hf0, OK);
            wr(a, {24'h0, 4'hf, v[3:0]}, OK);
            rd(a, {OK, 24'h0, 4'hf, v[3:0]});
        end
        chk("pin_oe", 32'hffff, {16'h0, pin_oe});
        chk("pin_out", {16'h0, lvl}, {16'h0, pin_out});
        // Old direction gates level bits
        wr(P0 + 16'h40, 32'h0b, OK);
        wr(P0 + 16'h40, 32'h05, OK);
        wr(P0 + 16'h40, 32'hf3, OK);
        @(posedge aclk);
        chk("level 7 4", 32'hb, {28'h0, pin_out[7:4]});
        ext_level[4] <= 1'b1;
        wr(`DPRR_ADDR_SEG_MAP, 32'h10, OK);
        repeat (2) @(posedge aclk);
        chk("oe 7 4", 32'he, {28'h0, pin_oe[7:4]});
        rd(P0 + 16'h40, {OK, 24'h0, 8'hfa});
        wr(P0, 32'h0, OK);
        wr(`DPRR_ADDR_SEG_MAP, 32'h0, OK);
        v = $random(seed);
        {pulse_out_a, pulse_out_b, eeprom_do, eeprom_oe} <= v[3:0];
        wr(`DPRR_ADDR_PIN_OPT, 32'h7, OK);
        repeat (2) @(posedge aclk);
        eb = {1'b1, v[3], 1'b1, v[2], v[0], v[1]};
        ob = {pin_oe[0], pin_out[0], pin_oe[1], pin_out[1], pin_oe[3],
              pin_out[3]};
        chk("pins 0 1 3", {26'h0, eb}, {26'h0, ob});
        wr(`DPRR_ADDR_PIN_OPT, 32'h0, OK);
        for (int i = 1; i < 4; i++)
            wr(P0 + {8'h0, i[1:0], 6'h0}, 32'h0, OK);
        wr(BAD, 32'h1, `DPRR_RESP_DECERR);
        rd(BAD, {`DPRR_RESP_DECERR, 32'h0});
        vold = {15'h0, pushbutton_in, ext_level};
        // All codes reach all selectors
        for (int t = 0; t < 24; t++)
        begin
            for (int k = 0; k < 11; k++)
                sel[k] = 3'(t + k);
            wr(RPB, {29'h0, sel[10]}, OK);
            for (int j = 0; j < 5; j++)
            begin
                a = R23 - {11'h0, j[2:0], 2'h0};
                wr(a, {25'h0, sel[2*j+1], 1'b0, sel[2*j]}, OK);
            end
            rd(R23, {OK, 25'h0, sel[1], 1'b0, sel[0]});
            v = $random(seed);
            ext_level <= v[15:0];
            pushbutton_in <= v[16];
            repeat (3) @(posedge aclk);
            chk("early", {28'h0, res_of(vold)}, {28'h0, resources});
            repeat (2) @(posedge aclk);
            chk("res", {28'h0, res_of(v)}, {28'h0, resources});
            vold = v;
        end
        complete_run();
    end
endmodule : dio_port_resource_router_tb

/* dprr_board.sv */
// Board-side model of the port pads
`timescale 1ns/1ns
module dprr_board (
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    input  wire logic [15:0] ext_level,
    output logic      [15:0] pin_in
);
    // Block where enabled, board elsewhere
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : dprr_board

/* dprr_map.svh */
// Offsets, fields and reset values of the port router
`ifndef DPRR_MAP_SVH
`define DPRR_MAP_SVH

// Register indices; byte address = 4 x index
`define DPRR_IDX_PORT_0_3      16'h0080
`define DPRR_IDX_PORT_4_7      16'h0090
`define DPRR_IDX_PORT_8_11     16'h00a0
`define DPRR_IDX_PORT_12_15    16'h00b0
`define DPRR_IDX_ROUTE_PB      16'h2450
`define DPRR_IDX_ROUTE_10_11   16'h2451
`define DPRR_IDX_ROUTE_8_9     16'h2452
`define DPRR_IDX_ROUTE_6_7     16'h2453
`define DPRR_IDX_ROUTE_4_5     16'h2454
`define DPRR_IDX_ROUTE_2_3     16'h2455

// Byte addresses of own config words
`define DPRR_ADDR_SEG_MAP      16'h0000
`define DPRR_ADDR_PIN_OPT      16'h0004

// Port register fields
`define DPRR_PORT_LVL_LSB      0
`define DPRR_PORT_DIR_LSB      4
// Route select register fields
`define DPRR_ROUTE_LO_LSB      0
`define DPRR_ROUTE_HI_LSB      4
// Option register fields
`define DPRR_OPT_PULSE_A_BIT   0
`define DPRR_OPT_PULSE_B_BIT   1
`define DPRR_OPT_EEPROM_LSB    2

// Reset values
`define DPRR_RST_DIR           16'h0000
`define DPRR_RST_LEVEL         16'hffff
`define DPRR_RST_SEG_MAP       16'h0000
`define DPRR_RST_ROUTE         3'h0

// Bus answers
`define DPRR_RESP_OKAY         2'h0
`define DPRR_RESP_DECERR       2'h3

`endif

/* dprr_pkg.sv */
// Types of the port router
package dprr_pkg;

    // Resource selector codes 0 to 5
    typedef enum logic [2:0] {
        DPRR_RES_NONE,
        DPRR_RES_RESERVED,
        DPRR_RES_TIMER0,
        DPRR_RES_TIMER1,
        DPRR_RES_INT_A,
        DPRR_RES_INT_B
    } dprr_res_e;

    // Inputs to the internal resources
    typedef struct packed {
        logic timer0_input;
        logic timer1_input;
        logic ext_interrupt_a;
        logic ext_interrupt_b;
    } dprr_res_s;

    // Option overrides of shared segment pins
    typedef struct packed {
        logic [1:0] eeprom_pin_option;
        logic       pulse_out_b_select;
        logic       pulse_out_a_select;
    } dprr_opt_s;

endpackage : dprr_pkg

/* dprr_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module dprr_sync #(
    parameter int WIDTH = 11
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : dprr_sync

/* dprr_top.sv */
// Digital port with pin direction and resource routing
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`include "dprr_map.svh"

// How it works
// [R1] Selector codes: none, reserved, timers, interrupts
// [R2] Pins 2 to 11 each own selector
// [R3] Pins sharing a resource are ORed
// [R4] Sixteen direction bits, one means output
// [R5] Direction ignored on segment-assigned pins
// [R6] Pins above 15 not directed here
// [R7] Pulse and EEPROM options override shared pins not segment-assigned
// [R8] Segment pins read back as zero
// [R9] Level writes drive output pins
// [R10] Level writes skip input and segment pins
// [R11] Routed inputs pass two-stage synchroniser
module dprr_top
    import dprr_pkg::*;
#(
    parameter int NPIN   = 16,
    parameter int NROUTE = 11
) (
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic [15:0]     s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    input  wire logic [15:0]     s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    input  wire logic [NPIN-1:0] pin_in,
    output logic      [NPIN-1:0] pin_out,
    output logic      [NPIN-1:0] pin_oe,
    input  wire logic            pushbutton_in,
    input  wire logic            pulse_out_a,
    input  wire logic            pulse_out_b,
    input  wire logic            eeprom_do,
    input  wire logic            eeprom_oe,
    output dprr_res_s            resources
);

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses

    localparam logic [15:0] A_PORT0  = `DPRR_IDX_PORT_0_3 * 16'h4;
    localparam logic [15:0] A_PORT1  = `DPRR_IDX_PORT_4_7 * 16'h4;
    localparam logic [15:0] A_PORT2  = `DPRR_IDX_PORT_8_11 * 16'h4;
    localparam logic [15:0] A_PORT3  = `DPRR_IDX_PORT_12_15 * 16'h4;
    localparam logic [15:0] A_RT_PB  = `DPRR_IDX_ROUTE_PB * 16'h4;
    localparam logic [15:0] A_RT_10  = `DPRR_IDX_ROUTE_10_11 * 16'h4;
    localparam logic [15:0] A_RT_8   = `DPRR_IDX_ROUTE_8_9 * 16'h4;
    localparam logic [15:0] A_RT_6   = `DPRR_IDX_ROUTE_6_7 * 16'h4;
    localparam logic [15:0] A_RT_4   = `DPRR_IDX_ROUTE_4_5 * 16'h4;
    localparam logic [15:0] A_RT_2   = `DPRR_IDX_ROUTE_2_3 * 16'h4;

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [NPIN-1:0] pin_direction;
    logic [NPIN-1:0] level_latch;
    logic [NPIN-1:0] seg_map;
    dprr_opt_s       pin_opt;
    // Index 0..9: pins 2..11; 10: pushbutton
    dprr_res_e       route_sel [NROUTE];

    logic            aw_held;
    logic [15:0]     aw_addr;
    logic            w_held;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;

    logic            aw_hs;
    logic            w_hs;
    logic            ar_hs;
    logic            do_write;
    logic            wr_lane0;
    logic            next_aw_held;
    logic            next_w_held;
    logic            next_bvalid;
    logic            next_rvalid;

    logic [31:0]     read_word;
    logic            read_ok;
    logic            write_ok;

    logic [NROUTE-1:0] routed_raw;
    logic [NROUTE-1:0] routed_sync;
    dprr_res_s         next_resources;
    logic [NPIN-1:0]   next_pin_out;
    logic [NPIN-1:0]   next_pin_oe;
    logic [NPIN-1:0]   level_writable;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes

    assign aw_hs    = s_axi_awvalid && s_axi_awready;
    assign w_hs     = s_axi_wvalid && s_axi_wready;
    assign ar_hs    = s_axi_arvalid && s_axi_arready;
    // Address and data may arrive in either order
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_lane0 = do_write && w_strb[0];

    assign next_aw_held = (aw_held || aw_hs) && !do_write;
    assign next_w_held  = (w_held || w_hs) && !do_write;
    assign next_bvalid  = (s_axi_bvalid && !s_axi_bready) || do_write;
    assign next_rvalid  = (s_axi_rvalid && !s_axi_rready) || ar_hs;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held       <= 1'b0;
            aw_addr       <= 16'h0000;
            s_axi_awready <= 1'b0;
        end
        else
        begin
            aw_held       <= next_aw_held;
            s_axi_awready <= !next_aw_held && !next_bvalid;
            if (aw_hs)
                aw_addr <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            w_held       <= next_w_held;
            s_axi_wready <= !next_w_held && !next_bvalid;
            if (w_hs)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `DPRR_RESP_OKAY;
        end
        else
        begin
            s_axi_bvalid <= next_bvalid;
            if (do_write)
                s_axi_bresp <= write_ok ? `DPRR_RESP_OKAY
                                        : `DPRR_RESP_DECERR;
        end
    end

    // One read in flight; address decoded when taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `DPRR_RESP_OKAY;
        end
        else
        begin
            s_axi_rvalid  <= next_rvalid;
            s_axi_arready <= !next_rvalid;
            if (ar_hs)
            begin
                s_axi_rdata <= read_ok ? read_word : 32'h0000_0000;
                s_axi_rresp <= read_ok ? `DPRR_RESP_OKAY
                                       : `DPRR_RESP_DECERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode

    always_comb
    begin
        read_word = 32'h0000_0000;
        read_ok   = 1'b1;
        unique case (s_axi_araddr)
            // [R8] Segment pins read zero
            A_PORT0: read_word[7:0] = {pin_direction[3:0],
                                       pin_in[3:0] & ~seg_map[3:0]};
            A_PORT1: read_word[7:0] = {pin_direction[7:4],
                                       pin_in[7:4] & ~seg_map[7:4]};
            A_PORT2: read_word[7:0] = {pin_direction[11:8],
                                       pin_in[11:8] & ~seg_map[11:8]};
            A_PORT3: read_word[7:0] = {pin_direction[15:12],
                                       pin_in[15:12] & ~seg_map[15:12]};
            A_RT_2:  read_word[7:0] = {1'b0, route_sel[1],
                                       1'b0, route_sel[0]};
            A_RT_4:  read_word[7:0] = {1'b0, route_sel[3],
                                       1'b0, route_sel[2]};
            A_RT_6:  read_word[7:0] = {1'b0, route_sel[5],
                                       1'b0, route_sel[4]};
            A_RT_8:  read_word[7:0] = {1'b0, route_sel[7],
                                       1'b0, route_sel[6]};
            A_RT_10: read_word[7:0] = {1'b0, route_sel[9],
                                       1'b0, route_sel[8]};
            A_RT_PB: read_word[7:0] = {5'h00, route_sel[10]};
            `DPRR_ADDR_SEG_MAP: read_word[15:0] = seg_map;
            `DPRR_ADDR_PIN_OPT: read_word[3:0]  = pin_opt;
            default: read_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        unique case (aw_addr)
            A_PORT0, A_PORT1, A_PORT2, A_PORT3,
            A_RT_2, A_RT_4, A_RT_6, A_RT_8, A_RT_10, A_RT_PB,
            `DPRR_ADDR_SEG_MAP, `DPRR_ADDR_PIN_OPT: write_ok = 1'b1;
            default: write_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Direction and output level

    // [R10] Only output, non-segment pins take level writes
    assign level_writable = pin_direction & ~seg_map;

    // [R4] One direction bit per pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pin_direction <= `DPRR_RST_DIR;
        else if (wr_lane0)
        begin
            unique case (aw_addr)
                A_PORT0: pin_direction[3:0]   <= w_data[7:4];
                A_PORT1: pin_direction[7:4]   <= w_data[7:4];
                A_PORT2: pin_direction[11:8]  <= w_data[7:4];
                A_PORT3: pin_direction[15:12] <= w_data[7:4];
                default: ;
            endcase
        end
    end

    // [R9] Latch new levels of output pins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            level_latch <= `DPRR_RST_LEVEL;
        else if (wr_lane0)
        begin
            for (int g = 0; g < 4; g++)
            begin
                if (aw_addr == A_PORT0 + 16'(g * 64))
                begin
                    for (int j = 0; j < 4; j++)
                    begin
                        if (level_writable[g*4+j])
                            level_latch[g*4+j] <= w_data[j];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Segment map and pin options

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            seg_map <= `DPRR_RST_SEG_MAP;
        else if (do_write && aw_addr == `DPRR_ADDR_SEG_MAP)
        begin
            if (w_strb[0])
                seg_map[7:0] <= w_data[7:0];
            if (w_strb[1])
                seg_map[15:8] <= w_data[15:8];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pin_opt <= '0;
        else if (wr_lane0 && aw_addr == `DPRR_ADDR_PIN_OPT)
            pin_opt <= w_data[3:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Route selectors

    // [R2] Separate 3-bit selector per pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int k = 0; k < NROUTE; k++)
                route_sel[k] <= dprr_res_e'(`DPRR_RST_ROUTE);
        end
        else if (wr_lane0)
        begin
            unique case (aw_addr)
                A_RT_2:
                begin
                    route_sel[0] <= dprr_res_e'(w_data[2:0]);
                    route_sel[1] <= dprr_res_e'(w_data[6:4]);
                end
                A_RT_4:
                begin
                    route_sel[2] <= dprr_res_e'(w_data[2:0]);
                    route_sel[3] <= dprr_res_e'(w_data[6:4]);
                end
                A_RT_6:
                begin
                    route_sel[4] <= dprr_res_e'(w_data[2:0]);
                    route_sel[5] <= dprr_res_e'(w_data[6:4]);
                end
                A_RT_8:
                begin
                    route_sel[6] <= dprr_res_e'(w_data[2:0]);
                    route_sel[7] <= dprr_res_e'(w_data[6:4]);
                end
                A_RT_10:
                begin
                    route_sel[8] <= dprr_res_e'(w_data[2:0]);
                    route_sel[9] <= dprr_res_e'(w_data[6:4]);
                end
                A_RT_PB: route_sel[10] <= dprr_res_e'(w_data[2:0]);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Resource routing

    assign routed_raw = {pushbutton_in, pin_in[11:2]};

    // [R11] Synchronise before combining
    dprr_sync #(
        .WIDTH    (NROUTE)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (routed_raw),
        .sync_out (routed_sync)
    );

    // Codes 0, 1, 6 and 7 reach no resource
    always_comb
    begin
        next_resources = '0;
        for (int k = 0; k < NROUTE; k++)
        begin
            // [R1] Decode selector code
            // [R3] OR all pins on a resource
            unique case (route_sel[k])
                DPRR_RES_TIMER0:
                    next_resources.timer0_input |= routed_sync[k];
                DPRR_RES_TIMER1:
                    next_resources.timer1_input |= routed_sync[k];
                DPRR_RES_INT_A:
                    next_resources.ext_interrupt_a |= routed_sync[k];
                DPRR_RES_INT_B:
                    next_resources.ext_interrupt_b |= routed_sync[k];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            resources <= '0;
        else
            resources <= next_resources;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive
    // [R6] Only pins 0 to 15 are directed here

    always_comb
    begin
        // [R5] Segment pins never driven from here
        next_pin_oe  = pin_direction & ~seg_map;
        next_pin_out = level_latch;
        // [R7] Dedicated options take the shared pins unless segment-assigned
        if (pin_opt.pulse_out_a_select && !seg_map[0])
        begin
            next_pin_out[0] = pulse_out_a;
            next_pin_oe[0]  = 1'b1;
        end
        if (pin_opt.pulse_out_b_select && !seg_map[1])
        begin
            next_pin_out[1] = pulse_out_b;
            next_pin_oe[1]  = 1'b1;
        end
        if (pin_opt.eeprom_pin_option != 2'h0 && !seg_map[3])
        begin
            next_pin_out[3] = eeprom_do;
            next_pin_oe[3]  = eeprom_oe;
        end
    end

    // Registered so the pads see no decode glitches
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out <= `DPRR_RST_LEVEL;
            pin_oe  <= '0;
        end
        else
        begin
            pin_out <= next_pin_out;
            pin_oe  <= next_pin_oe;
        end
    end

endmodule : dprr_top

/* dprr_top_properties.sv */
// Concurrent checks on the port router outputs
`timescale 1ns/1ns
module dprr_top_checker
    import dprr_pkg::*;
#(
    parameter int NPIN   = 16,
    parameter int NROUTE = 11
) (
    input wire logic            aclk,
    input wire logic            aresetn,
    input wire logic            s_axi_awvalid,
    input wire logic            s_axi_awready,
    input wire logic            s_axi_wvalid,
    input wire logic            s_axi_wready,
    input wire logic [1:0]      s_axi_bresp,
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_bready,
    input wire logic [15:0]     s_axi_araddr,
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic [31:0]     s_axi_rdata,
    input wire logic [1:0]      s_axi_rresp,
    input wire logic            s_axi_rvalid,
    input wire logic            s_axi_rready,
    input wire logic [NPIN-1:0] pin_in,
    input wire logic            pushbutton_in,
    input wire dprr_res_s       resources
);
    // Cycles since a pin move or bus write
    logic [2:0] quiet;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || $changed(pin_in) || $changed(pushbutton_in) ||
            s_axi_awvalid || s_axi_bvalid)
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    ////////////////////////////////////////
    // Resources follow synchronised pins
    a_res_quiet: assert property (quiet[2] |-> $stable(resources))
        else $error("resources moved while quiet");
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("bresp missing");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("rvalid missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped early");
    a_unmapped_read: assert property (s_rd_taken and s_axi_araddr == 16'h0008
        |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_one_write: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
endmodule : dprr_top_checker

bind dprr_top dprr_top_checker #(.NPIN(NPIN), .NROUTE(NROUTE)) i_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pushbutton_in,
    .resources
);
